// File: hdl/timer16_cc.sv
// 16-bit up-counter with two capture/compare registers, mode control and APB slave.
// Assumes APB3/4 master on pclk; timer pins are asynchronous and synchronised here.
//
// Summary of operation
// (R1) Input A capture uses opposite edge.
// (R2) Input B capture uses selected edge.
// (R3) Software never writes edge code 10.
// (R4) Edge and trigger fields at fixed bits.
// (R5) Clear-on-match needs nonzero capture_compare_a.
// (R6) Zero compare A fires leaving zero after wrap.
// (R7) Shared pin is input B or output.
// (R8) Read/capture collision tolerated; capture stays correct.
// (R9) Software leaves capture_compare_a alone while running.
// (R10) capture_compare_b writable while running.
// (R11) Bit 2 picks B mode; reset zero.
// (R12) B compare match raises match_irq_b.
// (R13) B captures on input A edge.
// (R14) Zero compare B fires after wrap/clear.
// (R15) Nonzero mode starts; zero stops and clears.
// (R16) Mode bits 3:2 select stop/free/edge/match.
// (R17) Output toggles on matches, optionally input edge.
// (R18) Match interrupts only while running.
// (R19) Overflow flag sets on FFFF wrap.
// (R20) Software stops counter before mode changes.
// (R21) Mode register resets zero; top nibble zero.
// (R22) Counter advances per count tick, read-only.
// (R23) A compare match raises match_irq_a.
// (R24) Trigger select picks input B or A.
// (R25) Trigger pulses outlast two count clocks.
// (R26) Inputs synchronised and edge detected first.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/100ps
module timer16_cc #(
  parameter int SLOW_DIV_LOG2 = timer16_pkg::SLOW_DIV_LOG2
) (
  // Clock and reset
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  // APB slave
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [timer16_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [timer16_pkg::DATA_W-1:0]  pwdata,
  input  wire logic [3:0]                      pstrb,
  output logic      [timer16_pkg::DATA_W-1:0]  prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  // Timer pins
  input  wire logic                            timer_input_a,
  input  wire logic                            shared_port_pin_in,
  output logic                                 shared_port_pin_out,
  output logic                                 shared_port_pin_oe_n,
  // Match events
  output logic                                 match_irq_a,
  output logic                                 match_irq_b
);
  localparam int CW = timer16_pkg::CNT_W;
  localparam int DW = timer16_pkg::DATA_W;

  initial begin
    if (SLOW_DIV_LOG2 < 3 || SLOW_DIV_LOG2 > 16) begin
      $error("SLOW_DIV_LOG2 out of range");
    end
  end

  typedef struct packed {
    logic [CW-1:0] count;
    logic [CW-1:0] cca;
    logic [CW-1:0] ccb;
    logic [1:0]    cnt_mode;
    logic          toggle_sel;
    logic          ovf;
    logic [7:0]    prescale;
    logic [2:0]    cc_ctrl;
    logic          pin_out_sel;
    logic          out_level;
    logic          wrapped;
    logic          irq_a;
    logic          irq_b;
    logic [DW-1:0] rdata;
    logic          err;
  } state_t;

  state_t r;
  state_t s;

  timer_edges_if edges ();

  logic       tick;
  logic       running;
  logic [1:0] sel_a;
  logic [1:0] sel_b;
  logic       valid_a;
  logic       valid_b;
  logic       rev_a;
  logic       cca_capture;
  logic       ccb_capture;
  logic       trig_a;
  logic       match_a;
  logic       match_b;
  logic       edge_clear;
  logic [15:0] idx;
  logic       hit;
  logic       setup;
  logic       wr;

  // Input synchronisers and edge detection
  timer_input_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .in_a    (timer_input_a),
    .in_b    (shared_port_pin_in),
    .edges   (edges)
  );

  // Count clock enable, restarted on stop
  timer_count_clock #(
    .SLOW_DIV_LOG2 (SLOW_DIV_LOG2)
  ) u_clk (
    .pclk     (pclk),
    .presetn  (presetn),
    .run      (running),
    .clk_sel  (r.prescale[timer16_pkg::PRE_CLK_HI:timer16_pkg::PRE_CLK_LO]),
    .ext_edge (valid_a),
    .tick     (tick)
  );

  // Merge a 16-bit write under the two low byte strobes
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0]  strb);
    logic [15:0] m;
    m = old_v;
    if (strb[0]) begin
      m[7:0] = new_v[7:0];
    end
    if (strb[1]) begin
      m[15:8] = new_v[15:8];
    end
    return m;
  endfunction

  // Edge decode of one input; the forbidden code detects nothing
  function automatic logic edge_pick(input logic [1:0] sel,
                                     input logic       rise,
                                     input logic       fall);
    logic v;
    v = 1'b0;
    unique case (sel)
      timer16_pkg::EDGE_FALL: v = fall;
      timer16_pkg::EDGE_RISE: v = rise;
      timer16_pkg::EDGE_BOTH: v = rise | fall;
      timer16_pkg::EDGE_BAD:  v = 1'b0;
    endcase
    return v;
  endfunction

  // Field decode and event terms
  always_comb begin
    running     = (r.cnt_mode != timer16_pkg::CNT_STOP);
    sel_a       = r.prescale[timer16_pkg::PRE_EA_HI:timer16_pkg::PRE_EA_LO];  // [R4]
    sel_b       = r.prescale[timer16_pkg::PRE_EB_HI:timer16_pkg::PRE_EB_LO];  // [R4]
    valid_a     = edge_pick(sel_a, edges.rise_a, edges.fall_a);
    // Pin used as output gives no input B edges [R7]
    valid_b     = ~r.pin_out_sel & edge_pick(sel_b, edges.rise_b, edges.fall_b);  // [R2]
    // Reverse phase: a rising setting captures falling edges, both captures none
    unique case (sel_a)
      timer16_pkg::EDGE_FALL: rev_a = edges.rise_a;  // [R1]
      timer16_pkg::EDGE_RISE: rev_a = edges.fall_a;  // [R1]
      default:                rev_a = 1'b0;          // [R1]
    endcase
    cca_capture = r.cc_ctrl[timer16_pkg::CC_A_MODE_BIT];                  // [R4]
    ccb_capture = r.cc_ctrl[timer16_pkg::CC_B_MODE_BIT];                  // [R11]
    trig_a      = r.cc_ctrl[timer16_pkg::CC_A_TRIG_BIT] ? rev_a : valid_b;  // [R24]
    // A zero compare value only matches once zero was reached by wrap or clear
    match_a     = running & tick & ~cca_capture & (r.count == r.cca) &
                  ((r.cca != '0) | r.wrapped);                            // [R23] [R6]
    match_b     = running & tick & ~ccb_capture & (r.count == r.ccb) &
                  ((r.ccb != '0) | r.wrapped);                            // [R12] [R14]
    edge_clear  = running & (r.cnt_mode == timer16_pkg::CNT_CLR_EDGE) & valid_a;  // [R16]
  end

  // APB decode; unaligned or unmapped addresses answer with an error
  always_comb begin
    idx   = paddr[timer16_pkg::ADDR_W-1:2];
    hit   = (paddr[1:0] == 2'h0) &&
            (idx == timer16_pkg::IDX_COUNTER  || idx == timer16_pkg::IDX_CCA ||
             idx == timer16_pkg::IDX_CCB      || idx == timer16_pkg::IDX_MODE ||
             idx == timer16_pkg::IDX_PRESCALE || idx == timer16_pkg::IDX_CC_CTRL ||
             idx == timer16_pkg::IDX_PIN_CTRL);
    setup = psel & ~penable;
    wr    = psel & penable & pwrite & ~r.err;
  end

  // Next state: bus first, then hardware events so that events win
  always_comb begin
    s       = r;
    s.irq_a = 1'b0;
    s.irq_b = 1'b0;

    // Read data captured in the setup phase, shown in the access phase
    if (setup) begin
      s.err   = ~hit;
      s.rdata = '0;
      unique case (idx)
        timer16_pkg::IDX_COUNTER:  s.rdata[CW-1:0] = r.count;   // [R22]
        timer16_pkg::IDX_CCA:      s.rdata[CW-1:0] = r.cca;     // [R8]
        timer16_pkg::IDX_CCB:      s.rdata[CW-1:0] = r.ccb;     // [R8]
        // Top nibble of the mode register reads zero [R21]
        timer16_pkg::IDX_MODE:     s.rdata[3:0] = {r.cnt_mode, r.toggle_sel, r.ovf};
        timer16_pkg::IDX_PRESCALE: s.rdata[7:0] = {r.prescale[7:4], 2'h0,
                                                   r.prescale[1:0]};
        timer16_pkg::IDX_CC_CTRL:  s.rdata[2:0] = r.cc_ctrl;
        timer16_pkg::IDX_PIN_CTRL: s.rdata[0] = r.pin_out_sel;
        default:                   s.rdata = '0;
      endcase
    end

    // Register writes take effect at the access edge
    if (wr) begin
      unique case (idx)
        timer16_pkg::IDX_CCA: s.cca = merge16(r.cca, pwdata[15:0], pstrb[1:0]);
        // Accepted at any time so the compare value can move on the fly [R10]
        timer16_pkg::IDX_CCB: s.ccb = merge16(r.ccb, pwdata[15:0], pstrb[1:0]);
        timer16_pkg::IDX_MODE: begin
          if (pstrb[0]) begin
            s.cnt_mode   = pwdata[timer16_pkg::MODE_CNT_HI:timer16_pkg::MODE_CNT_LO];  // [R15]
            s.toggle_sel = pwdata[timer16_pkg::MODE_TOGGLE_BIT];
            s.ovf        = pwdata[timer16_pkg::MODE_OVF_BIT];
          end
        end
        timer16_pkg::IDX_PRESCALE: begin
          if (pstrb[0]) begin
            s.prescale = {pwdata[7:4], 2'h0, pwdata[1:0]};
          end
        end
        timer16_pkg::IDX_CC_CTRL: begin
          if (pstrb[0]) begin
            s.cc_ctrl = pwdata[2:0];
          end
        end
        timer16_pkg::IDX_PIN_CTRL: begin
          if (pstrb[0]) begin
            s.pin_out_sel = pwdata[timer16_pkg::PIN_OUT_SEL_BIT];
          end
        end
        default: s.err = r.err;
      endcase
    end

    // Counter: held at zero while stopped, so stop also clears it
    if (!running) begin
      s.count   = '0;                                 // [R15]
      s.wrapped = 1'b0;
    end else if (edge_clear) begin
      s.count   = '0;                                 // [R16]
      s.wrapped = 1'b1;
    end else if (tick) begin
      if (r.cnt_mode == timer16_pkg::CNT_CLR_MATCH && match_a) begin
        s.count   = '0;                               // [R16] [R5]
        s.wrapped = 1'b1;
      end else if (r.count == timer16_pkg::COUNT_MAX) begin
        s.count   = '0;
        s.wrapped = 1'b1;
      end else begin
        s.count = r.count + 1'b1;                     // [R22]
      end
    end

    // Overflow flag; a wrap in the same cycle as a clearing write wins
    if (running && tick && r.count == timer16_pkg::COUNT_MAX) begin
      s.ovf = 1'b1;                                   // [R19]
    end

    // Captures only while counting; stop and trigger together is undefined anyway
    if (running && cca_capture && trig_a) begin
      s.cca = r.count;                                // [R1] [R2] [R24]
    end
    if (running && ccb_capture && valid_a) begin
      s.ccb = r.count;                                // [R13]
    end

    // Match events, never raised while stopped
    s.irq_a = match_a;                                // [R18]
    s.irq_b = match_b;                                // [R18]

    // Output flip-flop holds still while stopped
    if (running && (match_a || match_b || (r.toggle_sel && valid_a))) begin
      s.out_level = ~r.out_level;                     // [R17]
    end
  end

  // Single state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r          <= '0;
      r.cca      <= timer16_pkg::RST_CC;
      r.ccb      <= timer16_pkg::RST_CC;              // [R11]
      r.prescale <= timer16_pkg::RST_BYTE;
      r.cnt_mode <= timer16_pkg::CNT_STOP;            // [R21]
    end else begin
      r <= s;
    end
  end

  // Bus answer: no wait states, error only on a bad address
  assign prdata  = r.rdata;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & r.err;

  // Shared pin: driven only when selected as the timer output [R7]
  assign shared_port_pin_out  = r.out_level;
  assign shared_port_pin_oe_n = ~r.pin_out_sel;

  // Registered one-cycle match pulses
  assign match_irq_a = r.irq_a;
  assign match_irq_b = r.irq_b;
endmodule

// File: inc/timer16_pkg.sv
// Constants shared by the 16-bit timer: register indices, field positions, codes, resets.
// Assumes APB with 32-bit data; byte address of a register is four times its index.
package timer16_pkg;

  // Bus geometry
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 16;

  // Register indices; byte address is index * 4
  localparam logic [15:0] IDX_COUNTER   = 16'hff16;
  localparam logic [15:0] IDX_CCA       = 16'hff7a;
  localparam logic [15:0] IDX_CCB       = 16'hff7c;
  localparam logic [15:0] IDX_MODE      = 16'hff7e;
  localparam logic [15:0] IDX_PRESCALE  = 16'hff7f;
  localparam logic [15:0] IDX_CC_CTRL   = 16'hff6a;
  localparam logic [15:0] IDX_PIN_CTRL  = 16'hff60;

  // Timer mode register fields
  localparam int MODE_OVF_BIT    = 0;
  localparam int MODE_TOGGLE_BIT = 1;
  localparam int MODE_CNT_LO     = 2;
  localparam int MODE_CNT_HI     = 3;

  // Prescaler mode register fields
  localparam int PRE_CLK_LO = 0;
  localparam int PRE_CLK_HI = 1;
  localparam int PRE_EA_LO  = 4;
  localparam int PRE_EA_HI  = 5;
  localparam int PRE_EB_LO  = 6;
  localparam int PRE_EB_HI  = 7;

  // Capture/compare control and pin control fields
  localparam int CC_A_MODE_BIT   = 0;
  localparam int CC_A_TRIG_BIT   = 1;
  localparam int CC_B_MODE_BIT   = 2;
  localparam int PIN_OUT_SEL_BIT = 0;

  // Counter mode codes
  localparam logic [1:0] CNT_STOP      = 2'h0;
  localparam logic [1:0] CNT_FREE      = 2'h1;
  localparam logic [1:0] CNT_CLR_EDGE  = 2'h2;
  localparam logic [1:0] CNT_CLR_MATCH = 2'h3;

  // Edge select codes; code 2 is forbidden and detects nothing
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BAD  = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Count clock select codes
  localparam logic [1:0] CLK_DIV2   = 2'h0;
  localparam logic [1:0] CLK_DIV4   = 2'h1;
  localparam logic [1:0] CLK_DIVLOW = 2'h2;
  localparam logic [1:0] CLK_EXT    = 2'h3;
  localparam int SLOW_DIV_LOG2 = 8;

  // Reset values
  localparam logic [7:0]       RST_BYTE  = 8'h00;
  localparam logic [CNT_W-1:0] RST_CC    = 16'h0000;
  localparam logic [CNT_W-1:0] COUNT_MAX = 16'hffff;

endpackage

// File: inc/timer_edges_if.sv
// Edge events of the two synchronised timer inputs, carried from synchroniser to users.
// Assumes one clock domain; every event is a one-cycle pulse.
`timescale 1ns/100ps
interface timer_edges_if;
  logic rise_a;
  logic fall_a;
  logic rise_b;
  logic fall_b;
  modport src (output rise_a, output fall_a, output rise_b, output fall_b);
  modport dst (input rise_a, input fall_a, input rise_b, input fall_b);
endinterface

// File: hdl/timer_input_sync.sv
// Two-flop synchronisers and edge detectors for the two timer inputs.
// Assumes the inputs are asynchronous pins; edges appear two cycles after the pin moves.
`timescale 1ns/100ps
module timer_input_sync (
  // Clock and reset
  input  wire logic   pclk,
  input  wire logic   presetn,
  // Raw pins
  input  wire logic   in_a,
  input  wire logic   in_b,
  // Edge events
  timer_edges_if.src  edges
);
  typedef struct packed {
    logic a_s1;
    logic a_s2;
    logic a_d;
    logic b_s1;
    logic b_s2;
    logic b_d;
  } sync_t;

  sync_t r;
  sync_t s;

  // First stage feeds only the second stage
  always_comb begin
    s      = r;
    s.a_s1 = in_a;
    s.a_s2 = r.a_s1;
    s.a_d  = r.a_s2;
    s.b_s1 = in_b;
    s.b_s2 = r.b_s1;
    s.b_d  = r.b_s2;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= s;
    end
  end

  // Edges from the settled stage only [R26]
  assign edges.rise_a = r.a_s2 & ~r.a_d;
  assign edges.fall_a = ~r.a_s2 & r.a_d;
  assign edges.rise_b = r.b_s2 & ~r.b_d;
  assign edges.fall_b = ~r.b_s2 & r.b_d;
endmodule

// File: hdl/timer_count_clock.sv
// Count clock enable: pclk/2, pclk/4, pclk/2^SLOW_DIV_LOG2 or an external edge.
// Assumes run is low while the counter is stopped, which restarts the divider.
`timescale 1ns/100ps
module timer_count_clock #(
  parameter int SLOW_DIV_LOG2 = timer16_pkg::SLOW_DIV_LOG2
) (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic       run,
  input  wire logic [1:0] clk_sel,
  input  wire logic       ext_edge,
  // Count enable pulse
  output logic            tick
);
  initial begin
    if (SLOW_DIV_LOG2 < 3 || SLOW_DIV_LOG2 > 16) begin
      $error("SLOW_DIV_LOG2 out of range");
    end
  end

  typedef struct packed {
    logic [SLOW_DIV_LOG2-1:0] div;
    logic                     tick;
  } div_t;

  div_t r;
  div_t s;

  // Divider and tick select; the tick is registered to keep it glitch free
  always_comb begin
    s.div  = run ? r.div + 1'b1 : '0;
    s.tick = 1'b0;
    if (run) begin
      unique case (clk_sel)
        timer16_pkg::CLK_DIV2:   s.tick = r.div[0];
        timer16_pkg::CLK_DIV4:   s.tick = &r.div[1:0];
        timer16_pkg::CLK_DIVLOW: s.tick = &r.div;
        timer16_pkg::CLK_EXT:    s.tick = ext_edge;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= s;
    end
  end

  assign tick = r.tick;
endmodule

// File: tb/timer16_cc_checker.sv
// Port checker for the 16-bit timer, bound into its top module.
// Assumes one pclk domain and whole-byte writes to the mode register.
`timescale 1ns/100ps
module timer16_cc_checker (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  // Timer side
  input wire logic        shared_port_pin_out,
  input wire logic        shared_port_pin_oe_n,
  input wire logic        match_irq_a,
  input wire logic        match_irq_b
);
  logic       wr_ok;
  logic       rd_ok;
  logic [3:0] mode_r;
  logic       pin_sel_r;
  logic [1:0] stop_cnt_r;

  // Transfers as the slave takes them
  assign wr_ok = psel && penable && pready && pwrite;
  assign rd_ok = psel && penable && !pwrite;

  // Shadow of mode and pin select; stop age saturates so late matches can drain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r     <= 4'h0;
      pin_sel_r  <= 1'b0;
      stop_cnt_r <= 2'h0;
    end else begin
      if (wr_ok && paddr == {timer16_pkg::IDX_MODE, 2'b00}) begin
        mode_r <= pwdata[3:0];
      end
      if (wr_ok && paddr == {timer16_pkg::IDX_PIN_CTRL, 2'b00}) begin
        pin_sel_r <= pwdata[0];
      end
      if (mode_r[3:2] != 2'h0) begin
        stop_cnt_r <= 2'h0;
      end else if (stop_cnt_r != 2'h3) begin
        stop_cnt_r <= stop_cnt_r + 2'h1;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_irq_a_single: assert property (match_irq_a |=> !match_irq_a)
    else $error("match a longer than a cycle");
  a_irq_b_single: assert property (match_irq_b |=> !match_irq_b)
    else $error("match b longer than a cycle");
  a_stop_quiet: assert property (stop_cnt_r == 2'h3 |-> !match_irq_a && !match_irq_b)
    else $error("match while stopped");
  a_stop_count_zero: assert property (rd_ok && stop_cnt_r == 2'h3 &&
      paddr == {timer16_pkg::IDX_COUNTER, 2'b00} |-> prdata == 32'h0)
    else $error("stopped count not zero");
  a_mode_readback: assert property (rd_ok && paddr == {timer16_pkg::IDX_MODE, 2'b00}
      |-> prdata[31:1] == {28'h0, mode_r[3:1]})
    else $error("mode register readback wrong");
  a_pin_oe_sel: assert property (shared_port_pin_oe_n == !pin_sel_r)
    else $error("pin enable disagrees with select");
  a_toggle_cause: assert property ($changed(shared_port_pin_out) && !mode_r[1]
      |-> match_irq_a || match_irq_b)
    else $error("output toggled without match");
  a_stop_out_hold: assert property (stop_cnt_r == 2'h3 |-> $stable(shared_port_pin_out))
    else $error("output moved while stopped");

  c_match_a: cover property (match_irq_a);
  c_match_b: cover property (match_irq_b);
  c_toggle: cover property ($changed(shared_port_pin_out));
endmodule

bind timer16_cc timer16_cc_checker u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .shared_port_pin_out(shared_port_pin_out), .shared_port_pin_oe_n(shared_port_pin_oe_n),
  .match_irq_a(match_irq_a), .match_irq_b(match_irq_b)
);

// File: tb/timer_pulse_source.sv
// Pulse sources on the two timer input pins.
// Assumes the bench requests levels; a new level waits out the old one's width.
`timescale 1ns/100ps
module timer_pulse_source #(
  parameter int MIN_HOLD = 12
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Requested levels
  input  wire logic want_a,
  input  wire logic want_b,
  // Pin levels
  output logic      pin_a,
  output logic      pin_b
);
  int age_a;
  int age_b;

  // Narrow pulses would slip past capture, so each level stands its minimum
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_a <= 1'b0;
      pin_b <= 1'b0;
      age_a <= 0;
      age_b <= 0;
    end else begin
      pin_a <= (age_a >= MIN_HOLD) ? want_a : pin_a;
      pin_b <= (age_b >= MIN_HOLD) ? want_b : pin_b;
      age_a <= (age_a >= MIN_HOLD && pin_a != want_a) ? 0 : age_a + 1;
      age_b <= (age_b >= MIN_HOLD && pin_b != want_b) ? 0 : age_b + 1;
    end
  end
endmodule

// File: tb/tb_timer16_cc.sv
// Self-checking bench for the 16-bit timer with capture/compare.
// Assumes the checker is bound in and the pulse source drives the pins.
`timescale 1ns/100ps
module tb_timer16_cc;
  typedef struct {
    logic [15:0] idx;
    logic [31:0] wd;
    logic [31:0] exp;
    logic        err;
  } row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_err;
  logic        pin_a, src_b, pin_b, pin_out, pin_oe_n, irq_a, irq_b, want_a, want_b;
  logic [17:0] paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, rd_data, saved;
  int          err_count, checked, n_ev;
  localparam logic [15:0] MODE = timer16_pkg::IDX_MODE, CCA = timer16_pkg::IDX_CCA;
  localparam logic [15:0] CCB = timer16_pkg::IDX_CCB, PRE = timer16_pkg::IDX_PRESCALE;
  localparam logic [15:0] CTL = timer16_pkg::IDX_CC_CTRL, CNT = timer16_pkg::IDX_COUNTER;
  localparam logic [15:0] PIN = timer16_pkg::IDX_PIN_CTRL;
  // Write then read back; all registers start at zero
  row_t        rows[8] = '{
    '{MODE, 32'hf0, 32'h00, 1'b0},
    '{CCB, 32'h1234, 32'h1234, 1'b0},
    '{CCA, 32'habcd, 32'habcd, 1'b0},
    '{PRE, 32'hff, 32'hf3, 1'b0},
    '{CTL, 32'hff, 32'h07, 1'b0},
    '{PIN, 32'h01, 32'h01, 1'b0},
    '{CNT, 32'h5555, 32'h00, 1'b0},
    '{16'hff00, 32'h01, 32'h00, 1'b1}};

  timer16_cc #(.SLOW_DIV_LOG2(3)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_input_a(pin_a), .shared_port_pin_in(pin_b),
    .shared_port_pin_out(pin_out), .shared_port_pin_oe_n(pin_oe_n),
    .match_irq_a(irq_a), .match_irq_b(irq_b));
  timer_pulse_source u_src (.pclk(pclk), .presetn(presetn), .want_a(want_a),
    .want_b(want_b), .pin_a(pin_a), .pin_b(src_b));

  // Shared pin: the device drives it while its enable is low
  assign pin_b = pin_oe_n ? src_b : pin_out;
  always #4 pclk = ~pclk;

  task automatic print_verdict;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic fail(input string what);
    err_count++;
    $display("[FAIL] %0t %s", $time, what);
  endtask
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      fail(what);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp, input string what);
    check_word({31'h0, got}, {31'h0, exp}, what);
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 50) begin
        fail("apb timeout");
        print_verdict();
      end
      @(posedge pclk);
    end
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Bounded wait for a match pulse
  task automatic wait_irq(input logic on_b, input int lim);
    logic seen;
    seen = 1'b0;
    for (int n = 0; n < lim && seen !== 1'b1; n++) begin
      @(posedge pclk);
      seen = on_b ? irq_b : irq_a;
    end
    checked++;
    if (seen !== 1'b1) begin
      fail("no match event");
      print_verdict();
    end
  endtask
  // New pin level, then time to cross the synchroniser
  task automatic set_pin(input logic on_b, input logic v);
    @(posedge pclk);
    want_a <= on_b ? want_a : v;
    want_b <= on_b ? v : want_b;
    repeat (30) @(posedge pclk);
  endtask

  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0;
    pwdata = '0; pstrb = 4'hf; want_a = 0; want_b = 0; err_count = 0; checked = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b0, rows[i].idx, 32'h0);
      check_word(rd_data, 32'h0, "reset value");
      apb(1'b1, rows[i].idx, rows[i].wd);
      apb(1'b0, rows[i].idx, 32'h0);
      check_word(rd_data, rows[i].exp, "read back");
      check_bit(rd_err, rows[i].err, "error response");
    end
    // Compare b in free run, rewritten on the fly, then stop
    apb(1'b1, PRE, 32'h0);
    apb(1'b1, CTL, 32'h0);
    apb(1'b1, CCA, 32'h0100);
    apb(1'b1, CCB, 32'h0005);
    apb(1'b1, MODE, 32'h04);
    wait_irq(1'b1, 100);
    check_bit(pin_out, 1'b1, "output toggled");
    apb(1'b1, CCB, 32'h0040);
    apb(1'b0, CCB, 32'h0);
    check_word(rd_data, 32'h0040, "compare b rewritten");
    wait_irq(1'b1, 300);
    check_bit(pin_out, 1'b0, "output toggled back");
    apb(1'b1, MODE, 32'h0);
    apb(1'b0, CNT, 32'h0);
    check_word(rd_data, 32'h0, "stopped count");
    n_ev = 0;
    repeat (40) begin
      @(posedge pclk);
      n_ev += int'(irq_a === 1'b1) + int'(irq_b === 1'b1);
    end
    check_word(n_ev, 0, "events while stopped");
    // Clear on match with compare a
    apb(1'b1, CCA, 32'h0003);
    apb(1'b1, MODE, 32'h0c);
    wait_irq(1'b0, 50);
    wait_irq(1'b0, 12);
    apb(1'b0, CNT, 32'h0);
    check_bit(rd_data <= 32'h3, 1'b1, "count bounded by compare a");
    // Captures from input a: b on the valid edge, a on the opposite one
    apb(1'b1, MODE, 32'h0);
    apb(1'b1, CTL, 32'h07);
    apb(1'b1, PRE, 32'h10);
    apb(1'b1, MODE, 32'h04);
    set_pin(1'b0, 1'b1);
    apb(1'b0, CCA, 32'h0);
    check_word(rd_data, 32'h3, "a ignores valid edge");
    apb(1'b0, CCB, 32'h0);
    saved = rd_data;
    check_bit(saved != 32'h0 && saved < 32'h40, 1'b1, "b captured");
    set_pin(1'b0, 1'b0);
    apb(1'b0, CCA, 32'h0);
    check_bit(rd_data > saved, 1'b1, "a captured on opposite edge");
    apb(1'b0, CCB, 32'h0);
    check_word(rd_data, saved, "b ignores other edge");
    // Both edges selected: a captures nothing
    apb(1'b1, MODE, 32'h0);
    apb(1'b1, CCA, 32'hffff);
    apb(1'b1, PRE, 32'h30);
    apb(1'b1, MODE, 32'h04);
    set_pin(1'b0, 1'b1);
    set_pin(1'b0, 1'b0);
    apb(1'b0, CCA, 32'h0);
    check_word(rd_data, 32'hffff, "a with both edges");
    // Input b capture on its selected falling edge
    apb(1'b1, MODE, 32'h0);
    apb(1'b1, PIN, 32'h0);
    apb(1'b1, PRE, 32'h0);
    apb(1'b1, CTL, 32'h01);
    apb(1'b1, MODE, 32'h04);
    check_bit(pin_oe_n, 1'b1, "pin released to input");
    set_pin(1'b1, 1'b1);
    apb(1'b0, CCA, 32'h0);
    check_word(rd_data, 32'hffff, "b rising ignored");
    set_pin(1'b1, 1'b0);
    apb(1'b0, CCA, 32'h0);
    check_bit(rd_data < 32'hffff, 1'b1, "b falling captured");
    print_verdict();
  end
endmodule
